// file: rtl/owsc_pkg.sv
package owsc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses).
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_FETCH_SKIP = 16'h81DC;
    localparam logic [15:0] OFS_PRE_HEIGHT = 16'h81E0;
    localparam logic [15:0] OFS_HEIGHT_DELTA = 16'h81E4;
    localparam logic [15:0] OFS_ACC_INIT = 16'h81E8;
    localparam logic [15:0] OFS_FIFO_TIMING = 16'h81EC;
    localparam logic [15:0] OFS_MAIN_ORIGIN = 16'h81F0;
    localparam logic [15:0] OFS_MAIN_EXTENT = 16'h81F4;
    localparam logic [15:0] OFS_OVL_ORIGIN = 16'h81F8;
    localparam logic [15:0] OFS_OVL_EXTENT = 16'h81FC;

    // ------------------------------------------------------------
    // Field positions and masks.
    // ------------------------------------------------------------
    localparam int FSK_ENABLE_BIT = 31;
    localparam int FSK_TOP_BIT = 30;
    localparam logic [31:0] FSK_MASK = 32'hDFF81FF8;
    localparam logic [31:0] PRE_HEIGHT_MASK = 32'h000007FF;
    localparam logic [31:0] HEIGHT_DELTA_MASK = 32'h000007FF;
    localparam logic [31:0] ACC_INIT_MASK = 32'h00000FFF;
    localparam logic [31:0] FIFO_TIMING_MASK = 32'h0005FFFF;
    localparam logic [31:0] WINDOW_MASK = 32'h07FF07FF;
    localparam logic [31:0] FIFO_TIMING_RESET = 32'h00003000;
    localparam logic [31:0] ZERO_RESET = 32'h00000000;
    localparam int FT_ROW_LOW_BIT = 15;
    localparam int FT_PRECHARGE_BIT = 16;
    localparam int FT_EDO_BIT = 18;

    // ------------------------------------------------------------
    // FIFO split codes and slot counts.
    // ------------------------------------------------------------
    localparam logic [4:0] SPLIT_24_0 = 5'h00;
    localparam logic [4:0] SPLIT_16_8 = 5'h08;
    localparam logic [4:0] SPLIT_12_12 = 5'h0C;
    localparam logic [4:0] SPLIT_8_16 = 5'h10;
    localparam logic [4:0] SPLIT_0_24 = 5'h18;
    localparam logic [4:0] SLOTS_TOTAL = 5'h18;

    // ------------------------------------------------------------
    // Row strobe timing in half memory clocks.
    // ------------------------------------------------------------
    localparam logic [3:0] HALF_1_5 = 4'h3;
    localparam logic [3:0] HALF_2_5 = 4'h5;
    localparam logic [3:0] HALF_3_5 = 4'h7;
    localparam logic [3:0] HALF_4_5 = 4'h9;

    // Blend modes that count as opaque overlay.
    localparam logic [2:0] BLEND_OPAQUE_A = 3'h0;
    localparam logic [2:0] BLEND_OPAQUE_B = 3'h1;

    // Window geometry as the compositor sees it.
    typedef struct packed {
        logic [10:0] x_start;
        logic [10:0] y_start;
        logic [10:0] width_m1;
        logic [10:0] height;
    } owsc_window_t;

    // Fetch skip settings as applied.
    typedef struct packed {
        logic active;
        logic primary_on_top;
        logic [9:0] stop_qw;
        logic [9:0] resume_qw;
    } owsc_skip_t;

    // Vertical scaler set, applied at vertical sync.
    typedef struct packed {
        logic [10:0] pre_height;
        logic [10:0] height_delta;
        logic [11:0] acc_init;
    } owsc_vscale_t;

    // Memory timing selections.
    typedef struct packed {
        logic [3:0] row_low_half;
        logic [3:0] precharge_half;
        logic fast_edo_select;
    } owsc_mem_t;

endpackage

// file: rtl/owsc_regs.sv
// Operation
// (R01) Fetch-skip fields are ignored unless the enable bit 31 is set.
// (R02) Fetch skipping acts only for opaque blend modes 000b or 001b.
// (R03) Skipped background fetches cover horizontal limits; vertical extent comes from the top window.
// (R04) Software keeps the background window full screen while skipping.
// (R05) Software sets stop-fetch bits 12-3 to the hidden quadword offset plus one.
// (R06) Software sets resume-fetch bits 28-19 to stop plus width minus one.
// (R07) Bit 30 clear puts the overlay stream on top, set puts the main.
// (R08) Bits 31 and 30 of the fetch-skip register reset to zero.
// (R09) Software loads the pre-scale height as unscaled height minus one.
// (R10) Software loads the height delta as unscaled minus scaled height.
// (R11) Software loads the accumulator start as minus scaled height, minus one.
// (R12) Vertical scale writes stay pending until the next vertical sync.
// (R13) The 5-bit split code divides 24 quadword slots between the streams.
// (R14) Software writes only the five defined split codes.
// (R15) Overlay FIFO at or below its threshold raises a refill request; here no request is raised while the overlay has zero slots.
// (R16) Main FIFO at or below its threshold raises a refill request; here no request is raised while the main stream has zero slots.
// (R17) Software keeps each threshold within its stream's slot allocation.
// (R18) Bit 15 picks 2.5 clock row low time, else 3.5 or 4.5 by control bit.
// (R19) Bit 16 picks 1.5 clock precharge, else 2.5 or 3.5 by control bit.
// (R20) Bit 18 picks single-cycle EDO access for peripheral-bus cycles only.
// (R21) Window start registers give first line plus one and first pixel plus one.
// (R22) Window size bits 10-0 give the displayed line count.
// (R23) Window size bits 26-16 give pixels per line minus one.
`timescale 1ns/10ps
`default_nettype none

module owsc_regs (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [15:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Compositor context.
    input wire logic i_vsync,
    input wire logic [2:0] i_blend_mode,
    input wire logic i_row_low_long,
    input wire logic i_precharge_long,
    input wire logic [4:0] i_main_fill,
    input wire logic [4:0] i_overlay_fill,
    // Settings to the compositor.
    output owsc_pkg::owsc_skip_t o_skip,
    output owsc_pkg::owsc_vscale_t o_vscale,
    output owsc_pkg::owsc_window_t o_main_window,
    output owsc_pkg::owsc_window_t o_overlay_window,
    output owsc_pkg::owsc_mem_t o_mem,
    output logic [4:0] o_main_slots,
    output logic [4:0] o_overlay_slots,
    output logic o_main_refill,
    output logic o_overlay_refill,
    output logic o_vscale_pending
);
    import owsc_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers.
    // ------------------------------------------------------------

    // Secondary slot count for a split code; reserved codes give zero.
    function automatic logic [4:0] overlay_slots_of(input logic [4:0] code);
        logic [4:0] slots;
        slots = 5'h00;
        case (code)
            SPLIT_16_8: slots = 5'h08;
            SPLIT_12_12: slots = 5'h0C;
            SPLIT_8_16: slots = 5'h10;
            SPLIT_0_24: slots = 5'h18;
            default: slots = 5'h00;
        endcase
        return slots;
    endfunction

    // Unpack a start/size register pair into window geometry.
    function automatic owsc_window_t window_of(input logic [31:0] origin, input logic [31:0] extent);
        owsc_window_t w;
        w.x_start = origin[26:16];
        w.y_start = origin[10:0];
        w.width_m1 = extent[26:16];
        w.height = extent[10:0];
        return w;
    endfunction

    // ------------------------------------------------------------
    // Register storage.
    // ------------------------------------------------------------
    logic [31:0] fetch_skip;
    logic [31:0] pre_height_wr;
    logic [31:0] height_delta_wr;
    logic [31:0] acc_init_wr;
    logic [31:0] fifo_timing;
    logic [31:0] main_origin;
    logic [31:0] main_extent;
    logic [31:0] overlay_origin;
    logic [31:0] overlay_extent;
    owsc_vscale_t vscale_live;
    logic pending;
    logic wr_en;
    logic access;

    // A transfer completes in its first access cycle; no wait states.
    assign access = i_psel && i_penable;
    assign wr_en = access && i_pwrite;
    assign o_pready = 1'b1;

    // Unmapped addresses answer with an error and read zero.
    always_comb begin
        case (i_paddr)
            OFS_FETCH_SKIP, OFS_PRE_HEIGHT, OFS_HEIGHT_DELTA, OFS_ACC_INIT,
            OFS_FIFO_TIMING, OFS_MAIN_ORIGIN, OFS_MAIN_EXTENT, OFS_OVL_ORIGIN,
            OFS_OVL_EXTENT: o_pslverr = 1'b0;
            default: o_pslverr = access;
        endcase
    end

    // Fetch-skip register; the whole register resets to zero.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fetch_skip <= ZERO_RESET; // R08
        end else if (wr_en && i_paddr == OFS_FETCH_SKIP) begin
            fetch_skip <= i_pwdata & FSK_MASK;
        end
    end

    // Plain control registers; window registers clear at reset, FIFO timing loads FIFO_TIMING_RESET.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fifo_timing <= FIFO_TIMING_RESET;
            main_origin <= ZERO_RESET;
            main_extent <= ZERO_RESET;
            overlay_origin <= ZERO_RESET;
            overlay_extent <= ZERO_RESET;
        end else if (wr_en) begin
            case (i_paddr)
                OFS_FIFO_TIMING: fifo_timing <= i_pwdata & FIFO_TIMING_MASK;
                OFS_MAIN_ORIGIN: main_origin <= i_pwdata & WINDOW_MASK;
                OFS_MAIN_EXTENT: main_extent <= i_pwdata & WINDOW_MASK;
                OFS_OVL_ORIGIN: overlay_origin <= i_pwdata & WINDOW_MASK;
                OFS_OVL_EXTENT: overlay_extent <= i_pwdata & WINDOW_MASK;
                default: fifo_timing <= fifo_timing;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Vertical scaler: written values wait for vertical sync.
    // ------------------------------------------------------------

    // Shadow copies hold what software wrote and read back.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_height_wr <= ZERO_RESET;
            height_delta_wr <= ZERO_RESET;
            acc_init_wr <= ZERO_RESET;
        end else if (wr_en) begin
            case (i_paddr)
                OFS_PRE_HEIGHT: pre_height_wr <= i_pwdata & PRE_HEIGHT_MASK;
                OFS_HEIGHT_DELTA: height_delta_wr <= i_pwdata & HEIGHT_DELTA_MASK;
                OFS_ACC_INIT: acc_init_wr <= i_pwdata & ACC_INIT_MASK;
                default: acc_init_wr <= acc_init_wr;
            endcase
        end
    end

    // Live set loads on vsync so a frame never mixes old and new factors.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            vscale_live <= '0;
        end else if (i_vsync) begin
            vscale_live.pre_height <= pre_height_wr[10:0]; // R12
            vscale_live.height_delta <= height_delta_wr[10:0]; // R12
            vscale_live.acc_init <= acc_init_wr[11:0]; // R12
        end
    end

    // Pending flag; a write in the vsync cycle wins so it is not lost.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pending <= 1'b0;
        end else if (wr_en && (i_paddr == OFS_PRE_HEIGHT || i_paddr == OFS_HEIGHT_DELTA
                               || i_paddr == OFS_ACC_INIT)) begin
            pending <= 1'b1; // R12
        end else if (i_vsync) begin
            pending <= 1'b0;
        end
    end

    // Limitation: a write landing in the vsync cycle itself waits one more frame.
    assign o_vscale_pending = pending;
    assign o_vscale = vscale_live;

    // ------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------

    // Read mux, registered on the setup edge, while penable is still low.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= ZERO_RESET;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
                OFS_FETCH_SKIP: o_prdata <= fetch_skip;
                OFS_PRE_HEIGHT: o_prdata <= pre_height_wr;
                OFS_HEIGHT_DELTA: o_prdata <= height_delta_wr;
                OFS_ACC_INIT: o_prdata <= acc_init_wr;
                OFS_FIFO_TIMING: o_prdata <= fifo_timing;
                OFS_MAIN_ORIGIN: o_prdata <= main_origin;
                OFS_MAIN_EXTENT: o_prdata <= main_extent;
                OFS_OVL_ORIGIN: o_prdata <= overlay_origin;
                OFS_OVL_EXTENT: o_prdata <= overlay_extent;
                default: o_prdata <= ZERO_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Fetch skip settings.
    // ------------------------------------------------------------
    logic skip_enable;
    logic opaque_mode;

    assign skip_enable = fetch_skip[FSK_ENABLE_BIT];
    assign opaque_mode = (i_blend_mode == BLEND_OPAQUE_A) || (i_blend_mode == BLEND_OPAQUE_B); // R02

    // Fields are zeroed while disabled, so nothing downstream sees them.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_skip <= '0;
        end else if (skip_enable) begin
            o_skip.active <= opaque_mode; // R02 R03
            o_skip.primary_on_top <= fetch_skip[FSK_TOP_BIT]; // R07
            o_skip.stop_qw <= fetch_skip[12:3]; // R03
            o_skip.resume_qw <= fetch_skip[28:19]; // R03
        end else begin
            o_skip <= '0; // R01
        end
    end

    // ------------------------------------------------------------
    // Windows, FIFO split and memory timing.
    // ------------------------------------------------------------

    // Window geometry straight from the start and size registers.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_main_window <= '0;
            o_overlay_window <= '0;
        end else begin
            o_main_window <= window_of(main_origin, main_extent); // R21 R22 R23
            o_overlay_window <= window_of(overlay_origin, overlay_extent); // R21 R22 R23
        end
    end

    // Slot split; the main stream gets whatever the overlay leaves.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_main_slots <= SLOTS_TOTAL;
            o_overlay_slots <= 5'h00;
        end else begin
            o_overlay_slots <= overlay_slots_of(fifo_timing[4:0]); // R13
            o_main_slots <= SLOTS_TOTAL - overlay_slots_of(fifo_timing[4:0]); // R13
        end
    end

    // Refill requests; a stream with no slots never requests.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_main_refill <= 1'b0;
            o_overlay_refill <= 1'b0;
        end else begin
            o_overlay_refill <= (o_overlay_slots != 5'h00) && (i_overlay_fill <= fifo_timing[9:5]); // R15
            o_main_refill <= (o_main_slots != 5'h00) && (i_main_fill <= fifo_timing[14:10]); // R16
        end
    end

    // Row strobe timing in half clocks; external bits pick the long options.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mem <= '0;
        end else begin
            o_mem.row_low_half <= fifo_timing[FT_ROW_LOW_BIT] ? HALF_2_5
                                  : (i_row_low_long ? HALF_4_5 : HALF_3_5); // R18
            o_mem.precharge_half <= fifo_timing[FT_PRECHARGE_BIT] ? HALF_1_5
                                    : (i_precharge_long ? HALF_3_5 : HALF_2_5); // R19
            o_mem.fast_edo_select <= fifo_timing[FT_EDO_BIT]; // R20
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    a_skip_off_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R01
        !skip_enable |=> !o_skip.active && o_skip.stop_qw == 10'h000)
        else $error("Fetch skip active while disabled.");

    a_skip_opaque_only: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R02
        o_skip.active |-> $past(opaque_mode) && $past(skip_enable))
        else $error("Fetch skip active outside opaque mode.");

    a_skip_fields: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R03
        skip_enable |=> o_skip.stop_qw == $past(fetch_skip[12:3])
                        && o_skip.resume_qw == $past(fetch_skip[28:19]))
        else $error("Fetch skip limits not taken from register.");

    a_top_select: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R07
        skip_enable |=> o_skip.primary_on_top == $past(fetch_skip[FSK_TOP_BIT]))
        else $error("Top layer select wrong.");

    a_vscale_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
        !i_vsync |=> $stable(vscale_live))
        else $error("Vertical scale changed without vsync.");

    a_vscale_load: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
        i_vsync |=> vscale_live.acc_init == $past(acc_init_wr[11:0]))
        else $error("Accumulator start not loaded at vsync.");

    a_split_total: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R13
        o_main_slots + o_overlay_slots == SLOTS_TOTAL)
        else $error("FIFO split does not sum to 24.");

    a_overlay_refill: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
        o_overlay_refill |-> $past(i_overlay_fill) <= $past(fifo_timing[9:5]))
        else $error("Overlay refill above threshold.");

    a_overlay_request: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
        o_overlay_slots != 5'h00 && i_overlay_fill <= fifo_timing[9:5] |=> o_overlay_refill)
        else $error("Overlay refill missing at threshold.");

    a_main_refill: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R16
        o_main_refill |-> $past(i_main_fill) <= $past(fifo_timing[14:10]))
        else $error("Main refill above threshold.");

    a_main_request: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R16
        o_main_slots != 5'h00 && i_main_fill <= fifo_timing[14:10] |=> o_main_refill)
        else $error("Main refill missing at threshold.");

    a_row_low_short: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R18
        fifo_timing[FT_ROW_LOW_BIT] |=> o_mem.row_low_half == HALF_2_5)
        else $error("Row low time not 2.5 clocks.");

    a_row_low_long: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R18
        !fifo_timing[FT_ROW_LOW_BIT] |=> o_mem.row_low_half == ($past(i_row_low_long) ? HALF_4_5 : HALF_3_5))
        else $error("Row low time ignores the long control bit.");

    a_precharge_short: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R19
        fifo_timing[FT_PRECHARGE_BIT] |=> o_mem.precharge_half == HALF_1_5)
        else $error("Precharge not 1.5 clocks.");

    a_precharge_long: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R19
        !fifo_timing[FT_PRECHARGE_BIT] |=> o_mem.precharge_half == ($past(i_precharge_long) ? HALF_3_5 : HALF_2_5))
        else $error("Precharge ignores the long control bit.");

    a_edo_select: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R20
        1'b1 |=> o_mem.fast_edo_select == $past(fifo_timing[FT_EDO_BIT]))
        else $error("EDO select not taken from register.");

    a_window_start: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R21
        1'b1 |=> o_main_window.x_start == $past(main_origin[26:16])
                 && o_overlay_window.y_start == $past(overlay_origin[10:0]))
        else $error("Window start fields wrong.");

    a_window_size: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R22 R23
        1'b1 |=> o_main_window.height == $past(main_extent[10:0])
                 && o_overlay_window.width_m1 == $past(overlay_extent[26:16]))
        else $error("Window size fields wrong.");

endmodule

`default_nettype wire

// file: sim/owsc_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none

module owsc_regs_bench;
    import owsc_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals.
    // ------------------------------------------------------------
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [15:0] i_paddr = 16'h0000;
    logic [31:0] i_pwdata = 32'h00000000;
    logic i_vsync = 1'b0;
    logic [2:0] i_blend_mode = 3'h0;
    logic i_row_low_long = 1'b0;
    logic i_precharge_long = 1'b0;
    logic [4:0] i_main_fill = 5'h18;
    logic [4:0] i_overlay_fill = 5'h18;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    owsc_skip_t o_skip;
    owsc_vscale_t o_vscale;
    owsc_window_t o_main_window;
    owsc_window_t o_overlay_window;
    owsc_mem_t o_mem;
    logic [4:0] o_main_slots;
    logic [4:0] o_overlay_slots;
    logic o_main_refill;
    logic o_overlay_refill;
    logic o_vscale_pending;
    int bad_count = 0;
    int cmp_count = 0;
    logic [31:0] q;
    logic err;
    logic [4:0] codes [5] = '{SPLIT_24_0, SPLIT_16_8, SPLIT_12_12, SPLIT_8_16, SPLIT_0_24};
    logic [4:0] mains [5] = '{5'h18, 5'h10, 5'h0C, 5'h08, 5'h00};

    owsc_regs owsc_regs_inst (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_vsync(i_vsync), .i_blend_mode(i_blend_mode),
        .i_row_low_long(i_row_low_long), .i_precharge_long(i_precharge_long),
        .i_main_fill(i_main_fill), .i_overlay_fill(i_overlay_fill), .o_skip(o_skip),
        .o_vscale(o_vscale), .o_main_window(o_main_window), .o_overlay_window(o_overlay_window),
        .o_mem(o_mem), .o_main_slots(o_main_slots), .o_overlay_slots(o_overlay_slots),
        .o_main_refill(o_main_refill), .o_overlay_refill(o_overlay_refill),
        .o_vscale_pending(o_vscale_pending)
    );

    // ------------------------------------------------------------
    // Clock, verdict and bus tasks.
    // ------------------------------------------------------------
    // A 100 MHz clock.
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task stop_test;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
        end while (o_pready !== 1'b1);
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task rd(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(q, exp, "read data");
        check({err, o_pready}, 2'b01, "read answer");
    endtask

    // Registered outputs are looked at just after an edge, once updates have landed.
    task settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task apply_reset;
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        settle(2);
    endtask

    // ------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------
    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial begin
        apply_reset();
        rd(OFS_FETCH_SKIP, 32'h00000000);
        rd(OFS_FIFO_TIMING, 32'h00003000);
        check(o_main_slots, 5'h18, "main slots");
        check(o_mem.row_low_half, HALF_3_5, "row low");
        check(o_mem.precharge_half, HALF_2_5, "precharge");
        // Unmapped place: refused, reads zero, write leaves nothing behind.
        apb(1'b1, 16'h8200, 32'hFFFFFFFF);
        apb(1'b0, 16'h8200, 32'h00000000);
        check({q[30:0], err}, 32'h00000001, "unmapped");
        // Fields stay without effect while the enable bit is clear.
        apb(1'b1, OFS_FETCH_SKIP, 32'h55500AA8);
        settle(3);
        check(o_skip, '0, "skip off");
        apb(1'b1, OFS_FETCH_SKIP, 32'hF557EAAF);
        rd(OFS_FETCH_SKIP, 32'hD5500AA8);
        for (int m = 0; m < 8; m++) begin
            @(posedge i_ref_clk);
            i_blend_mode <= m[2:0];
            settle(3);
            check(o_skip, {m < 2, 1'b1, 10'h155, 10'h2AA}, "skip on");
        end
        @(posedge i_ref_clk);
        i_blend_mode <= BLEND_OPAQUE_B;
        apb(1'b1, OFS_FETCH_SKIP, 32'h95500AA8);
        settle(3);
        check(o_skip, {1'b1, 1'b0, 10'h155, 10'h2AA}, "overlay on top");
        // Scale writes wait for the vertical sync.
        apb(1'b1, OFS_PRE_HEIGHT, 32'hFFFFF123);
        apb(1'b1, OFS_HEIGHT_DELTA, 32'h00000456);
        apb(1'b1, OFS_ACC_INIT, 32'hFFFFFABC);
        settle(3);
        check({o_vscale_pending, o_vscale}, {1'b1, 34'h0}, "scale pending");
        rd(OFS_PRE_HEIGHT, 32'h00000123);
        rd(OFS_ACC_INIT, 32'h00000ABC);
        @(posedge i_ref_clk);
        i_vsync <= 1'b1;
        @(posedge i_ref_clk);
        i_vsync <= 1'b0;
        settle(2);
        check({o_vscale_pending, o_vscale}, {1'b0, 11'h123, 11'h456, 12'hABC}, "scale applied");
        // Every split code.
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, OFS_FIFO_TIMING, {27'h0, codes[k]});
            settle(3);
            check({o_main_slots, o_overlay_slots}, {mains[k], SLOTS_TOTAL - mains[k]}, "split");
        end
        // Refill requests at and just above each threshold, 12/12 split.
        apb(1'b1, OFS_FIFO_TIMING, 32'h0000188C);
        for (int f = 3; f < 9; f++) begin
            @(posedge i_ref_clk);
            i_overlay_fill <= f[4:0];
            i_main_fill <= f[4:0];
            settle(3);
            check(o_overlay_refill, f <= 4, "overlay refill");
            check(o_main_refill, f <= 6, "main refill");
        end
        // Row strobe and EDO selections against the external long bits.
        for (int i = 0; i < 16; i++) begin
            @(posedge i_ref_clk);
            i_row_low_long <= i[2];
            i_precharge_long <= i[3];
            apb(1'b1, OFS_FIFO_TIMING, 32'h0000000C | (i[0] << 15) | (i[1] << 16) | ((i[0] ^ i[1]) << 18));
            settle(3);
            check(o_mem.row_low_half, i[0] ? HALF_2_5 : (i[2] ? HALF_4_5 : HALF_3_5), "row low");
            check(o_mem.precharge_half, i[1] ? HALF_1_5 : (i[3] ? HALF_3_5 : HALF_2_5), "precharge");
            check(o_mem.fast_edo_select, i[0] ^ i[1], "edo");
        end
        // Window geometry, reserved bits dropped.
        apb(1'b1, OFS_MAIN_ORIGIN, 32'hF923F845);
        apb(1'b1, OFS_MAIN_EXTENT, 32'h02000100);
        apb(1'b1, OFS_OVL_ORIGIN, 32'h07FF0001);
        apb(1'b1, OFS_OVL_EXTENT, 32'hFC01F7FF);
        rd(OFS_MAIN_ORIGIN, 32'h01230045);
        rd(OFS_OVL_EXTENT, 32'h040107FF);
        settle(3);
        check(o_main_window, {11'h123, 11'h045, 11'h200, 11'h100}, "main window");
        check(o_overlay_window, {11'h7FF, 11'h001, 11'h401, 11'h7FF}, "overlay window");
        // A second reset in mid-run clears the enable bit again; the top bit is already clear from the last write.
        apply_reset();
        rd(OFS_FETCH_SKIP, 32'h00000000);
        check(o_skip, '0, "skip after reset");
        rd(OFS_FIFO_TIMING, 32'h00003000);
        stop_test();
    end

endmodule

`default_nettype wire
